// ==== dv/eoc_host_model.sv ====
// Host model: drives the serial command link one byte per frame.
// Assumes the decoder samples on rising link clock and shifts out on rising edges.
`default_nettype none
module eoc_host_model (
  output logic      link_sclk,
  output logic      cs_n,
  output logic      dc,
  output logic      sda_in,
  input  wire logic sda_out,
  input  wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_gap;
  logic oe_seen;

  initial begin
    oe_gap    = 1'b0;
    oe_seen   = 1'b0;
    link_sclk = 1'b0;
    cs_n      = 1'b1;
    dc        = 1'b0;
    sda_in    = 1'b0;
  end

  // ****************************************************************
  // One framed byte, MSB first; the clock stands still between frames
  // ****************************************************************
  task automatic xfer(input logic d_c, input logic [7:0] tx, output logic [7:0] rx);
    oe_gap = sda_oe;
    cs_n = 1'b0;
    dc   = d_c;
    for (int i = 7; i >= 0; i--) begin
      sda_in = tx[i];
      #62.5 link_sclk = 1'b1;
      #62.5 rx[i] = sda_out;
      oe_seen = sda_oe;
      link_sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    // Released data line shows the inverse so no stale value is mistaken for data.
    sda_in = ~sda_in;
    #1200;
  endtask : xfer
endmodule : eoc_host_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the command decoder.
// Assumes the package, the decoder and the host model are compiled before it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, nrst, link_sclk, cs_n, dc, sda_in, sda_out, sda_oe, gate;
  logic        ram_rd_next, rd_red, busy, pp1, pp2, pvi, fill_we, fill_red, fill_bit, frd;
  logic [7:0]  ram_rd_data, border, rx, hi;
  logic [35:0] ws;
  logic [31:0] mid;
  logic [9:0]  xs, xe, ys, ye, fx, fy;
  logic [15:0] fbits;
  logic [79:0] opt;
  logic [19:0] fend;
  int          error_cnt, n_checks, fcnt, rdn;

  eoc_host_model host (.link_sclk(link_sclk), .cs_n(cs_n), .dc(dc), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe));
  eoc_cmd_decoder dut (.clk(clk), .nrst(nrst), .link_sclk(link_sclk), .cs_n(cs_n), .dc(dc),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .clock_gate_flag(gate),
    .ram_rd_data(ram_rd_data), .ram_rd_next(ram_rd_next), .read_source_red(rd_red),
    .busy(busy), .waveform_state(ws), .pingpong_mode1(pp1), .pingpong_mode2(pp2),
    .module_id_version(mid), .prog_voltage_internal(pvi), .border_drive_output(border),
    .x_window_start(xs), .x_window_end(xe), .y_window_start(ys), .y_window_end(ye),
    .fill_we(fill_we), .fill_red(fill_red), .fill_x(fx), .fill_y(fy), .fill_bit(fill_bit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic cmd(input logic [7:0] b);
    host.xfer(1'b0, b, rx);
  endtask : cmd

  task automatic par(input logic [7:0] b);
    host.xfer(1'b1, b, rx);
  endtask : par

  task automatic wait_idle(input int bound);
    for (int k = 0; k < bound && busy !== 1'b0; k++) @(posedge clk);
    if (busy !== 1'b0) begin
      chk("busy timeout", 64'h0, 64'h1);
      wrap_up();
    end
  endtask : wait_idle

  task automatic win(input logic [7:0] c, input logic [9:0] s, input logic [9:0] e);
    cmd(c);
    par(s[7:0]);
    par({6'h00, s[9:8]});
    par(e[7:0]);
    par({6'h00, e[9:8]});
  endtask : win

  task automatic fill(input logic [7:0] c, input logic [7:0] p, input logic [8:0] eb,
                      input logic red, input logic [19:0] ea);
    fcnt = 0;
    cmd(c);
    par(p);
    wait_idle(4000);
    chk("fill count", 64'h9, 64'(fcnt));
    chk("fill end", 64'(ea), 64'(fend));
    chk("fill bits", 64'(eb), 64'(fbits[8:0]));
    chk("fill ram", 64'(red), 64'(frd));
  endtask : fill

  // Checksum over the selection area, bit 0 first, as the host would compute it.
  function automatic logic [15:0] crc_of(input logic [159:0] d);
    logic [15:0] c;
    c = eoc_pkg::CRC_INIT;
    for (int i = 0; i < 160; i++) c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ eoc_pkg::CRC_POLY)
                                                     : {c[14:0], 1'b0};
    return c;
  endfunction : crc_of

  always @(posedge clk) begin
    if (fill_we === 1'b1) begin
      fbits <= {fbits[14:0], fill_bit};
      fend  <= {fx, fy};
      fcnt  <= fcnt + 1;
      frd   <= fill_red;
      chk("busy in fill", 64'h1, 64'(busy));
    end
    if (ram_rd_next === 1'b1) rdn <= rdn + 1;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    gate = 1'b0;
    ram_rd_data = 8'hC3;
    error_cnt = 0;
    n_checks = 0;
    fcnt = 0;
    rdn = 0;
    opt = 80'hD4C3B2A1_8978563412_00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("x end", 64'h3BF, 64'(xe));
    chk("y end", 64'h2A7, 64'(ye));
    chk("x/y start", 64'h0, 64'({xs, ys}));
    chk("mode", 64'h0, 64'(pvi));
    chk("read src", 64'h0, 64'(rd_red));
    win(8'h44, 10'h105, 10'h20A);
    chk("x win", 64'h105_20A, 64'({xs, 12'h000} | {32'h0, xe}));
    win(8'h45, 10'h0A7, 10'h1FF);
    chk("y win", 64'h0A7_1FF, 64'({ys, 12'h000} | {32'h0, ye}));
    cmd(8'h3C);
    par(8'h5A);
    chk("border", 64'h5A, 64'(border));
    cmd(8'h39);
    par(8'h03);
    chk("int vpp", 64'h1, 64'(pvi));
    cmd(8'h39);
    par(8'h00);
    chk("normal", 64'h0, 64'(pvi));
    cmd(8'h37);
    for (int i = 0; i < 10; i++) par(opt[8*i+:8]);
    chk("ws", 64'h9_78563412, 64'(ws));
    chk("pingpong", 64'h2, 64'({pp1, pp2}));
    chk("module id", 64'hD4C3B2A1, 64'(mid));
    cmd(8'h34);
    chk("crc busy", 64'h1, 64'(busy));
    cmd(8'h3C);
    par(8'h11);
    wait_idle(400);
    chk("dropped", 64'h5A, 64'(border));
    cmd(8'h35);
    host.xfer(1'b1, 8'hFF, hi);
    par(8'hFF);
    chk("crc", 64'(crc_of(160'h0)), 64'({hi, rx}));
    cmd(8'h38);
    for (int i = 0; i < 10; i++) par(8'h40 + 8'(i));
    cmd(8'h36);
    chk("prog gated", 64'h0, 64'(busy));
    @(posedge clk) gate <= 1'b1;
    cmd(8'h36);
    chk("prog busy", 64'h1, 64'(busy));
    wait_idle(400);
    cmd(8'h34);
    wait_idle(400);
    cmd(8'h35);
    host.xfer(1'b1, 8'hFF, hi);
    par(8'hFF);
    chk("crc prog", 64'(crc_of({80'h49484746454443424140, opt})), 64'({hi, rx}));
    cmd(8'h41);
    par(8'h01);
    chk("red src", 64'h1, 64'(rd_red));
    cmd(8'h27);
    par(8'hFF);
    chk("dummy", 64'h00, 64'(rx));
    chk("drive en", 64'h1, 64'(host.oe_seen));
    par(8'hFF);
    chk("ram byte", 64'hC3, 64'(rx));
    chk("oe gap", 64'h0, 64'(host.oe_gap));
    chk("ram advance", 64'h2, 64'(rdn));
    cmd(8'h41);
    par(8'h00);
    chk("bw src", 64'h0, 64'(rd_red));
    win(8'h44, 10'h000, 10'h000);
    win(8'h45, 10'h000, 10'h008);
    fill(8'h46, 8'h80, 9'h1FE, 1'b1, 20'h00008);
    win(8'h44, 10'h000, 10'h008);
    win(8'h45, 10'h000, 10'h000);
    fill(8'h47, 8'h00, 9'h001, 1'b0, 20'h02000);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// ==== logic/eoc_cmd_decoder.sv ====
// Serial command decoder for checksum, selection programming, window and pattern fill.
// Assumes the host sends whole bytes, with a pause of at least 1 us between bytes.
`default_nettype none
module eoc_cmd_decoder (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        link_sclk,
  input  wire logic        cs_n,
  input  wire logic        dc,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        clock_gate_flag,
  input  wire logic [7:0]  ram_rd_data,
  output logic             ram_rd_next,
  output logic             read_source_red,
  output logic             busy,
  output logic [35:0]      waveform_state,
  output logic             pingpong_mode1,
  output logic             pingpong_mode2,
  output logic [31:0]      module_id_version,
  output logic             prog_voltage_internal,
  output logic [7:0]       border_drive_output,
  output logic [9:0]       x_window_start,
  output logic [9:0]       x_window_end,
  output logic [9:0]       y_window_start,
  output logic [9:0]       y_window_end,
  output logic             fill_we,
  output logic             fill_red,
  output logic [9:0]       fill_x,
  output logic [9:0]       fill_y,
  output logic             fill_bit
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? eoc_pkg::CRC_POLY : 16'h0000);
  endfunction : crc_step
  function automatic logic [9:0] step_len(input logic [2:0] code, input logic [9:0] last);
    step_len = (code == 3'h7) ? last : (10'h008 << code);
  endfunction : step_len

  // ****************************************************************
  // Link domain: byte assembly and read shifting
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] rx_byte;
    logic       rx_dc;
    logic       tgl;
  } eoc_lnk_s;
  typedef struct packed {
    eoc_pkg::eoc_op_e op;
    logic       busy;
    logic [7:0] cmd;
    logic [3:0] idx;
    logic [2:0] sync;
    logic       rd_mode;
    logic [7:0] tx_byte;
    logic       ram_rd_next;
    logic [15:0] crc;
    logic [7:0] cnt;
    logic [79:0] disp;
    logic [79:0] user;
    logic [159:0] otp_sel;
    logic [1:0] mode;
    logic       vpp_int;
    logic [7:0] border;
    logic       rd_src;
    logic [9:0] xs;
    logic [9:0] xe;
    logic [9:0] ys;
    logic [9:0] ye;
    logic [7:0] red_cfg;
    logic [7:0] mono_cfg;
    logic       fill_we;
    logic       fill_red;
    logic       fbit;
    logic [9:0] fx;
    logic [9:0] fy;
    logic [9:0] cx;
    logic [9:0] cy;
    logic       px;
    logic       py;
  } eoc_sys_s;

  eoc_lnk_s l;
  eoc_lnk_s next_l;
  eoc_sys_s q;
  eoc_sys_s next_q;
  always_comb begin
    next_l = l;
    if (!cs_n) begin
      next_l.sh  = {l.sh[6:0], sda_in};
      next_l.cnt = l.cnt + 3'h1;
      if (l.cnt == 3'h7) begin
        next_l.rx_byte = {l.sh[6:0], sda_in};
        next_l.rx_dc   = dc;
        next_l.tgl     = ~l.tgl;
      end
    end
  end
  always_ff @(posedge link_sclk or negedge nrst) begin
    if (!nrst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end
  // The select clears the pad driver at once, since the link clock stands still between frames.
  // Read mode and transmit byte are quasi-static, held by the host's pause between bytes.
  always_ff @(posedge link_sclk or negedge nrst) begin
    if (!nrst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= q.tx_byte[3'h7 - l.cnt];
    end
  end
  always_ff @(posedge link_sclk or negedge nrst or posedge cs_n) begin
    if (!nrst) begin
      sda_oe <= 1'b0;
    end else if (cs_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= dc && q.rd_mode;
    end
  end

  // ****************************************************************
  // System domain: command decode and operations
  // ****************************************************************
  logic       rx_evt;
  logic       is_cmd;
  logic [7:0] rx;
  logic [9:0] step_w;
  logic [9:0] step_h;
  assign rx_evt = q.sync[1] ^ q.sync[2];
  assign is_cmd = rx_evt && !l.rx_dc;
  assign rx     = l.rx_byte;
  assign step_h = step_len(q.fill_red ? q.red_cfg[6:4] : q.mono_cfg[6:4],
                           eoc_pkg::STEP_H_MAX);
  assign step_w = step_len(q.mono_cfg[2:0], eoc_pkg::STEP_W_MAX);
  always_comb begin
    next_q             = q;
    next_q.sync        = {q.sync[1:0], l.tgl};
    next_q.ram_rd_next = 1'b0;
    if (is_cmd) begin
      next_q.idx     = 4'h0;
      next_q.rd_mode = 1'b0;
      next_q.cmd     = q.busy ? eoc_pkg::CMD_NONE : rx;
      if (!q.busy) begin
        unique case (rx)
          eoc_pkg::CMD_CRC_CALC: begin
            next_q.op   = eoc_pkg::OP_CRC;
            next_q.busy = 1'b1;
            next_q.crc  = eoc_pkg::CRC_INIT;
            next_q.cnt  = 8'h00;
          end
          eoc_pkg::CMD_CRC_READ: begin
            next_q.rd_mode = 1'b1;
            next_q.tx_byte = q.crc[15:8];
          end
          eoc_pkg::CMD_OTP_PROG: begin
            if (clock_gate_flag) begin
              next_q.op   = eoc_pkg::OP_PROG;
              next_q.busy = 1'b1;
              next_q.cnt  = 8'h00;
            end
          end
          eoc_pkg::CMD_READ_RAM: begin
            next_q.rd_mode = 1'b1;
            next_q.tx_byte = eoc_pkg::DUMMY_BYTE;
          end
          default: ;
        endcase
      end
    end else if (rx_evt) begin
      next_q.idx = (q.idx == eoc_pkg::IDX_MAX) ? q.idx : q.idx + 4'h1;
      if (q.rd_mode) begin
        if (q.cmd == eoc_pkg::CMD_CRC_READ) begin
          next_q.tx_byte = q.crc[7:0];
        end else begin
          next_q.tx_byte     = ram_rd_data;
          next_q.ram_rd_next = 1'b1;
        end
      end else begin
        unique case (q.cmd)
          eoc_pkg::CMD_DISP_OPT: begin
            if (q.idx < 4'(eoc_pkg::BANK_BYTES)) begin
              next_q.disp[{q.idx, 3'b000} +: 8] = rx;
            end
          end
          eoc_pkg::CMD_USER_ID: begin
            if (q.idx < 4'(eoc_pkg::BANK_BYTES)) begin
              next_q.user[{q.idx, 3'b000} +: 8] = rx;
            end
          end
          eoc_pkg::CMD_PROG_MODE: begin
            if (q.idx == 4'h0) begin
              next_q.mode = rx[1:0];
              next_q.vpp_int = (rx[1:0] == eoc_pkg::MODE_INT_VPP);
            end
          end
          eoc_pkg::CMD_BORDER: begin
            if (q.idx == 4'h0) begin
              next_q.border = rx;
            end
          end
          eoc_pkg::CMD_READ_SRC: begin
            if (q.idx == 4'h0) begin
              next_q.rd_src = rx[0];
            end
          end
          eoc_pkg::CMD_X_WINDOW: begin
            unique case (q.idx)
              4'h0: next_q.xs[7:0] = rx;
              4'h1: next_q.xs[9:8] = rx[1:0];
              4'h2: next_q.xe[7:0] = rx;
              4'h3: next_q.xe[9:8] = rx[1:0];
              default: ;
            endcase
          end
          eoc_pkg::CMD_Y_WINDOW: begin
            unique case (q.idx)
              4'h0: next_q.ys[7:0] = rx;
              4'h1: next_q.ys[9:8] = rx[1:0];
              4'h2: next_q.ye[7:0] = rx;
              4'h3: next_q.ye[9:8] = rx[1:0];
              default: ;
            endcase
          end
          eoc_pkg::CMD_FILL_RED, eoc_pkg::CMD_FILL_MONO: begin
            if (q.idx == 4'h0) begin
              next_q.fill_red = (q.cmd == eoc_pkg::CMD_FILL_RED);
              if (q.cmd == eoc_pkg::CMD_FILL_RED) begin
                next_q.red_cfg = rx;
              end else begin
                next_q.mono_cfg = rx;
              end
              next_q.op      = eoc_pkg::OP_FILL;
              next_q.busy    = 1'b1;
              next_q.fill_we = 1'b1;
              next_q.fbit    = rx[eoc_pkg::FIRST_BIT];
              next_q.fx      = q.xs;
              next_q.fy      = q.ys;
              next_q.cx      = 10'h000;
              next_q.cy      = 10'h000;
              next_q.px      = 1'b0;
              next_q.py      = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    unique case (q.op)
      eoc_pkg::OP_IDLE: ;
      eoc_pkg::OP_CRC: begin
        next_q.crc = crc_step(q.crc, q.otp_sel[q.cnt]);
        next_q.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(eoc_pkg::CRC_BITS - 1)) begin
          next_q.op   = eoc_pkg::OP_IDLE;
          next_q.busy = 1'b0;
        end
      end
      eoc_pkg::OP_PROG: begin
        next_q.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(eoc_pkg::PROG_CYCLES - 1)) begin
          next_q.otp_sel = {q.user, q.disp};
          next_q.op      = eoc_pkg::OP_IDLE;
          next_q.busy    = 1'b0;
        end
      end
      eoc_pkg::OP_FILL: begin
        if (q.fx == q.xe && q.fy == q.ye) begin
          next_q.fill_we = 1'b0;
          next_q.op      = eoc_pkg::OP_IDLE;
          next_q.busy    = 1'b0;
        end else begin
          if (q.fx == q.xe) begin
            next_q.fx = q.xs;
            next_q.cx = 10'h000;
            next_q.px = 1'b0;
            next_q.fy = q.fy + 10'h001;
            next_q.cy = q.cy + 10'h001;
            if (q.cy + 10'h001 == step_h) begin
              next_q.cy = 10'h000;
              next_q.py = ~q.py;
            end
          end else begin
            next_q.fx = q.fx + 10'h001;
            next_q.cx = q.cx + 10'h001;
            if (q.cx + 10'h001 == step_w) begin
              next_q.cx = 10'h000;
              next_q.px = ~q.px;
            end
          end
          next_q.fbit = (q.fill_red ? q.red_cfg[eoc_pkg::FIRST_BIT]
                                    : q.mono_cfg[eoc_pkg::FIRST_BIT])
                        ^ next_q.py ^ (!q.fill_red & next_q.px);
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q          <= '0;
      q.op       <= eoc_pkg::OP_IDLE;
      q.cmd      <= eoc_pkg::CMD_NONE;
      q.mode     <= eoc_pkg::MODE_NORMAL;
      q.border   <= eoc_pkg::BORDER_RST;
      q.xs       <= eoc_pkg::X_START_RST;
      q.xe       <= eoc_pkg::X_END_RST;
      q.ys       <= eoc_pkg::Y_START_RST;
      q.ye       <= eoc_pkg::Y_END_RST;
      q.red_cfg  <= eoc_pkg::FILL_RST;
      q.mono_cfg <= eoc_pkg::FILL_RST;
    end else begin
      q <= next_q;
    end
  end
  assign ram_rd_next           = q.ram_rd_next;
  assign read_source_red       = q.rd_src;
  assign busy                  = q.busy;
  assign waveform_state        = q.disp[eoc_pkg::WS_MSB:eoc_pkg::WS_LSB];
  assign pingpong_mode1        = q.disp[eoc_pkg::PP_MODE1_BIT];
  assign pingpong_mode2        = q.disp[eoc_pkg::PP_MODE2_BIT];
  assign module_id_version     = q.disp[79:eoc_pkg::ID_LSB];
  assign prog_voltage_internal = q.vpp_int;
  assign border_drive_output   = q.border;
  assign x_window_start        = q.xs;
  assign x_window_end          = q.xe;
  assign y_window_start        = q.ys;
  assign y_window_end          = q.ye;
  assign fill_we               = q.fill_we;
  assign fill_red              = q.fill_red;
  assign fill_x                = q.fx;
  assign fill_y                = q.fy;
  assign fill_bit              = q.fbit;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_CRC_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    (is_cmd && !q.busy && rx == eoc_pkg::CMD_CRC_CALC) |=> q.busy[*8] ##153 !q.busy)
    else $error("checksum busy window wrong");
  AST_CRC_HI: assert property (@(posedge clk) disable iff (!nrst)
    (is_cmd && !q.busy && rx == eoc_pkg::CMD_CRC_READ) |=> q.rd_mode && q.tx_byte == q.crc[15:8])
    else $error("checksum high byte not first");
  AST_PROG_GATE: assert property (@(posedge clk) disable iff (!nrst)
    (is_cmd && !q.busy && rx == eoc_pkg::CMD_OTP_PROG && !clock_gate_flag) |=> !q.busy)
    else $error("programming started without clock gate");
  AST_MODE_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (rx_evt && l.rx_dc && !q.rd_mode && q.cmd == eoc_pkg::CMD_PROG_MODE && q.idx == 4'h0)
    |=> prog_voltage_internal == ($past(rx[1:0]) == 2'h3))
    else $error("program mode not loaded");
  AST_SRC_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (rx_evt && l.rx_dc && !q.rd_mode && q.cmd == eoc_pkg::CMD_READ_SRC && q.idx == 4'h0)
    |=> read_source_red == $past(rx[0]))
    else $error("read source not loaded");
  AST_XEND_HI: assert property (@(posedge clk) disable iff (!nrst)
    (rx_evt && l.rx_dc && !q.rd_mode && q.cmd == eoc_pkg::CMD_X_WINDOW && q.idx == 4'h3)
    |=> x_window_end[9:8] == $past(rx[1:0]) && $stable(x_window_end[7:0]))
    else $error("x end high bits wrong");
  AST_FILL_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    fill_we |-> busy)
    else $error("fill write without busy");
  AST_DUMMY: assert property (@(posedge clk) disable iff (!nrst)
    (is_cmd && !q.busy && rx == eoc_pkg::CMD_READ_RAM) |=> q.tx_byte == 8'h00 ##1 !ram_rd_next)
    else $error("first read byte not dummy");

endmodule : eoc_cmd_decoder
`default_nettype wire

// ==== logic/eoc_fix.sv ====
// Holds no logic; the decoder file carries the whole block.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

// ==== logic/eoc_pkg.sv ====
// Constants for the panel-driver command block covering commands 34h to 47h and the RAM read command 27h.
// Assumes a 20 MHz system clock and a host-driven serial link with its own clock.
`default_nettype none
package eoc_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_CRC_CALC   = 8'h34;
  localparam logic [7:0] CMD_CRC_READ   = 8'h35;
  localparam logic [7:0] CMD_OTP_PROG   = 8'h36;
  localparam logic [7:0] CMD_DISP_OPT   = 8'h37;
  localparam logic [7:0] CMD_USER_ID    = 8'h38;
  localparam logic [7:0] CMD_PROG_MODE  = 8'h39;
  localparam logic [7:0] CMD_BORDER     = 8'h3C;
  localparam logic [7:0] CMD_READ_SRC   = 8'h41;
  localparam logic [7:0] CMD_X_WINDOW   = 8'h44;
  localparam logic [7:0] CMD_Y_WINDOW   = 8'h45;
  localparam logic [7:0] CMD_FILL_RED   = 8'h46;
  localparam logic [7:0] CMD_FILL_MONO  = 8'h47;
  localparam logic [7:0] CMD_READ_RAM   = 8'h27;
  localparam logic [7:0] CMD_NONE       = 8'hFF;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int         BANK_BYTES     = 10;
  localparam logic [3:0] IDX_MAX        = 4'hF;
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_INT_VPP   = 2'h3;
  localparam logic [9:0] X_START_RST    = 10'h000;
  localparam logic [9:0] X_END_RST      = 10'h3BF;
  localparam logic [9:0] Y_START_RST    = 10'h000;
  localparam logic [9:0] Y_END_RST      = 10'h2A7;
  localparam logic [7:0] FILL_RST       = 8'h00;
  localparam logic [7:0] BORDER_RST     = 8'h00;
  localparam logic [7:0] DUMMY_BYTE     = 8'h00;
  localparam int         FIRST_BIT      = 7;
  localparam int         WS_LSB         = 8;
  localparam int         WS_MSB         = 43;
  localparam int         PP_MODE2_BIT   = 46;
  localparam int         PP_MODE1_BIT   = 47;
  localparam int         ID_LSB         = 48;
  localparam logic [9:0] STEP_H_MAX     = 10'h3C0;
  localparam logic [9:0] STEP_W_MAX     = 10'h2A8;

  // ****************************************************************
  // Checksum and timing
  // ****************************************************************
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam int          CRC_BITS      = 160;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          PROG_TIME_NS  = 10000;
  localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001,
    OP_CRC  = 4'b0010,
    OP_PROG = 4'b0100,
    OP_FILL = 4'b1000
  } eoc_op_e;

endpackage : eoc_pkg
`default_nettype wire
